// File: common/amd_pkg.sv
// constants, register map and state type of the accumulator/memory op decoder
// assumes a 32-bit classic wishbone slave port and a 17-bit instruction word
//
// Summary of operation
// - accumulator via pointer chosen by 2-bit selector field
// - low eight bits steer data address generator
// - offset bit picks accumulator or offset accumulator
// - string via s bit or index 11
// - first subclass: add, subtract, load, store
// - pointer pre-increment/decrement, never in string mode
// - string by index 11 keeps pointer unchanged
// - store picks accumulator by offset bit, transfer status
// - add, subtract, load update arithmetic status
// - second subclass never targets offset accumulators
// - or, and, xor into accumulator, arithmetic status
// - byte load zero-fills upper accumulator byte
// - byte store lane chosen by address lsb
// - compare sets flags, accumulator unchanged
// - table lookup program memory into data memory
// - multiply: low word to accumulator, high latched
// - code 1001 loads multiplier, subtracts product high
// - code 1010 loads multiplier, adds product high
// - those two chain flags when s bit set, execute once only
// - second subclass supports string but no pointer pre-increment/decrement
package amd_pkg;

   // ****************************************************************
   // register map (byte offsets)
   // ****************************************************************
   localparam logic [4:0] ADDR_INSTR    = 5'h00;
   localparam logic [4:0] ADDR_STRLEN   = 5'h04;
   localparam logic [4:0] ADDR_STATUS   = 5'h08;
   localparam logic [4:0] ADDR_MULT     = 5'h0c;
   localparam logic [4:0] ADDR_PRODHI   = 5'h10;
   localparam logic [4:0] ADDR_ACCSEL   = 5'h14;
   localparam logic [4:0] ADDR_ACCDATA  = 5'h18;
   localparam logic [4:0] ADDR_POINTERS = 5'h1c;

   // ****************************************************************
   // instruction field positions
   // ****************************************************************
   localparam int POS_CLASS_HI  = 16;
   localparam int POS_SUBCLASS  = 15;
   localparam int POS_OP1A_LO   = 13;
   localparam int POS_OFFSET    = 12;
   localparam int POS_NEXTA_LO  = 10;
   localparam int POS_OP1B_LO   = 11;
   localparam int POS_STRING    = 10;
   localparam int POS_ACCIDX_LO = 8;

   // ****************************************************************
   // opcodes and field codes
   // ****************************************************************
   localparam logic [1:0] OP1A_ADD   = 2'h0;
   localparam logic [1:0] OP1A_SUB   = 2'h1;
   localparam logic [1:0] OP1A_LOAD  = 2'h2;
   localparam logic [1:0] OP1A_STORE = 2'h3;
   localparam logic [3:0] OP1B_OR    = 4'h0;
   localparam logic [3:0] OP1B_AND   = 4'h1;
   localparam logic [3:0] OP1B_XOR   = 4'h2;
   localparam logic [3:0] OP1B_BLOAD = 4'h3;
   localparam logic [3:0] OP1B_BSTOR = 4'h4;
   localparam logic [3:0] OP1B_RSVD  = 4'h5;
   localparam logic [3:0] OP1B_CMP   = 4'h6;
   localparam logic [3:0] OP1B_TABLE = 4'h7;
   localparam logic [3:0] OP1B_MULT  = 4'h8;
   localparam logic [3:0] OP1B_SUBPH = 4'h9;
   localparam logic [3:0] OP1B_ADDPH = 4'ha;
   localparam logic [1:0] NEXTA_INC  = 2'h1;
   localparam logic [1:0] NEXTA_DEC  = 2'h2;
   localparam logic [1:0] IDX_STRING = 2'h3;

   // ****************************************************************
   // reset values
   // ****************************************************************
   localparam logic [16:0] RST_INSTR  = 17'h00000;
   localparam logic [7:0]  RST_STRLEN = 8'h00;
   localparam logic [15:0] RST_WORD   = 16'h0000;
   localparam logic [3:0]  RST_PTR    = 4'h0;

   typedef enum logic [1:0] {AMD_IDLE, AMD_ISSUE, AMD_WAIT, AMD_EXEC} amd_state_t;

endpackage

// File: design/amd_decoder.sv
// memory/accumulator instruction decoder and execution control with wishbone registers
// assumes a data address generator and memories that answer one cycle after a request
//
// Chosen here: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module amd_decoder #(
   parameter int ACC_WORDS = 16
) (
   input  wire logic        clk_sys,
   input  wire logic        srst,
   input  wire logic [31:0] wb_adr_i,
   input  wire logic [31:0] wb_dat_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic        wb_we_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   output logic             wb_ack_o,
   output logic [31:0]      wb_dat_o,
   output logic [7:0]       agen_adrs_o,
   output logic             agen_load_o,
   output logic             agen_step_o,
   input  wire logic        agen_addr_lsb_i,
   output logic             mem_rd_o,
   input  wire logic [15:0] mem_rdata_i,
   output logic             mem_wr_o,
   output logic [15:0]      mem_wdata_o,
   output logic [1:0]       mem_be_o,
   output logic             pmem_rd_o,
   output logic [15:0]      pmem_addr_o,
   input  wire logic [15:0] pmem_rdata_i
);

   // ****************************************************************
   // storage
   // ****************************************************************
   amd_pkg::amd_state_t state_reg;
   logic [16:0] instr_reg;
   logic [7:0]  strlen_reg;
   logic [7:0]  word_reg;
   logic [3:0]  ap_reg [4];
   logic [15:0] acc_file [2*ACC_WORDS];
   logic [15:0] mr_reg;
   logic [15:0] ph_reg;
   logic [4:0]  accsel_reg;
   logic        carry_reg;
   logic        zero_reg;
   logic        neg_reg;
   logic        xzero_reg;
   logic        xneg_reg;
   logic        mr_signed_reg;
   logic        bad_reg;
   logic        ack_reg;
   logic [31:0] rdata_reg;

   // ****************************************************************
   // decode of the held instruction
   // ****************************************************************
   logic       is_1a;
   logic [1:0] op1a;
   logic [3:0] op1b;
   logic [1:0] acc_idx;
   logic       string_mode;
   logic       once_op;
   logic       multi;
   logic [3:0] base;
   logic [4:0] src_addr;
   logic [4:0] tgt_addr;
   logic       is_store;
   logic       is_table;

   assign is_1a    = ~instr_reg[amd_pkg::POS_SUBCLASS];
   assign op1a     = instr_reg[amd_pkg::POS_OP1A_LO +: 2];
   assign op1b     = instr_reg[amd_pkg::POS_OP1B_LO +: 4];
   assign acc_idx  = instr_reg[amd_pkg::POS_ACCIDX_LO +: 2];
   // string by index code in 1a, by s bit in 1b
   assign string_mode = is_1a ? (acc_idx == amd_pkg::IDX_STRING)
                              : instr_reg[amd_pkg::POS_STRING];
   assign once_op  = ~is_1a & ((op1b == amd_pkg::OP1B_SUBPH) | (op1b == amd_pkg::OP1B_ADDPH));
   assign multi    = string_mode & ~once_op;
   // string steps walk from the pointer, pointer itself untouched
   assign base     = ap_reg[acc_idx] + word_reg[3:0];
   assign src_addr = {1'b0, base};
   // offset bank only in 1a
   assign tgt_addr = is_1a ? {instr_reg[amd_pkg::POS_OFFSET], base} : {1'b0, base};
   assign is_store = is_1a & (op1a == amd_pkg::OP1A_STORE);
   assign is_table = ~is_1a & (op1b == amd_pkg::OP1B_TABLE);

   // ****************************************************************
   // register bus decode
   // ****************************************************************
   logic bus_req;
   logic bus_wr;
   logic start_ok;
   logic sup_1b;

   assign bus_req  = wb_cyc_i & wb_stb_i & ~ack_reg;
   assign bus_wr   = bus_req & wb_we_i;
   assign sup_1b   = wb_dat_i[amd_pkg::POS_OP1B_LO +: 4] <= amd_pkg::OP1B_ADDPH;
   assign start_ok = bus_wr & (wb_adr_i[4:0] == amd_pkg::ADDR_INSTR) & (&wb_sel_i[2:0])
                     & (state_reg == amd_pkg::AMD_IDLE);

   // ****************************************************************
   // execution datapath
   // ****************************************************************
   logic [15:0] a_op;
   logic [15:0] m_op;
   logic [15:0] b_op;
   logic        chain;
   logic [16:0] sum_add;
   logic [16:0] sum_sub;
   logic [33:0] prod;
   logic [15:0] res;
   logic        res_c;
   logic        wr_acc;
   logic        wr_mem;
   logic [15:0] wdata;
   logic [1:0]  be;
   logic        upd_arith;
   logic        upd_xfer;
   logic        mr_load;
   logic        ph_load;
   logic        chain_c;

   assign a_op  = acc_file[src_addr];
   assign m_op  = mem_rdata_i;
   assign b_op  = once_op ? ph_reg : m_op;
   // later string words and the once-only ops with the s bit set chain carry and zero
   assign chain = (word_reg != 8'h00) | (once_op & string_mode);
   assign chain_c = chain & carry_reg;
   assign sum_add = {1'b0, a_op} + {1'b0, b_op} + {16'h0000, chain_c};
   assign sum_sub = {1'b0, a_op} + {1'b0, ~b_op} + {16'h0000, chain ? carry_reg : 1'b1};
   assign prod  = $signed({mr_signed_reg & mr_reg[15], mr_reg}) * $signed({m_op[15], m_op});

   // per-word operation select
   always_comb begin
      res       = a_op;
      res_c     = carry_reg;
      wr_acc    = 1'b0;
      wr_mem    = 1'b0;
      wdata     = a_op;
      be        = 2'h3;
      upd_arith = 1'b0;
      upd_xfer  = 1'b0;
      mr_load   = 1'b0;
      ph_load   = 1'b0;
      if (is_1a) begin
         case (op1a)
            amd_pkg::OP1A_ADD: begin
               {res_c, res} = sum_add;
               wr_acc       = 1'b1;
               upd_arith    = 1'b1;
            end
            amd_pkg::OP1A_SUB: begin
               {res_c, res} = sum_sub;
               wr_acc       = 1'b1;
               upd_arith    = 1'b1;
            end
            amd_pkg::OP1A_LOAD: begin
               res       = m_op;
               wr_acc    = 1'b1;
               upd_arith = 1'b1;
            end
            default: begin
               wdata    = acc_file[tgt_addr];
               wr_mem   = 1'b1;
               upd_xfer = 1'b1;
            end
         endcase
      end else begin
         case (op1b)
            amd_pkg::OP1B_OR, amd_pkg::OP1B_AND, amd_pkg::OP1B_XOR: begin
               res = (op1b == amd_pkg::OP1B_OR)  ? (a_op | m_op) :
                     (op1b == amd_pkg::OP1B_AND) ? (a_op & m_op) : (a_op ^ m_op);
               wr_acc    = 1'b1;
               upd_arith = 1'b1;
            end
            amd_pkg::OP1B_BLOAD: begin
               res       = {8'h00, agen_addr_lsb_i ? m_op[15:8] : m_op[7:0]};
               wr_acc    = 1'b1;
               upd_arith = 1'b1;
            end
            amd_pkg::OP1B_BSTOR: begin
               wdata    = {a_op[7:0], a_op[7:0]};
               be       = agen_addr_lsb_i ? 2'h2 : 2'h1;
               wr_mem   = 1'b1;
               upd_xfer = 1'b1;
            end
            amd_pkg::OP1B_CMP: begin
               {res_c, res} = sum_sub;
               upd_arith    = 1'b1;
            end
            amd_pkg::OP1B_TABLE: begin
               wdata    = pmem_rdata_i;
               wr_mem   = 1'b1;
               upd_xfer = 1'b1;
            end
            amd_pkg::OP1B_MULT: begin
               res       = prod[15:0];
               res_c     = 1'b0;
               wr_acc    = 1'b1;
               ph_load   = 1'b1;
               upd_arith = 1'b1;
            end
            amd_pkg::OP1B_SUBPH: begin
               {res_c, res} = sum_sub;
               wr_acc       = 1'b1;
               mr_load      = 1'b1;
               upd_arith    = 1'b1;
            end
            amd_pkg::OP1B_ADDPH: begin
               {res_c, res} = sum_add;
               wr_acc       = 1'b1;
               mr_load      = 1'b1;
               upd_arith    = 1'b1;
            end
            default: begin
               res = a_op;
            end
         endcase
      end
   end

   logic exec;
   logic last_word;
   assign exec      = state_reg == amd_pkg::AMD_EXEC;
   assign last_word = ~multi | (word_reg == strlen_reg);

   // ****************************************************************
   // sequencer
   // ****************************************************************
   // accept, fetch operand, execute, repeat per string word
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         state_reg <= amd_pkg::AMD_IDLE;
         word_reg  <= 8'h00;
         instr_reg <= amd_pkg::RST_INSTR;
         bad_reg   <= 1'b0;
      end else begin
         case (state_reg)
            amd_pkg::AMD_IDLE: begin
               if (start_ok) begin
                  instr_reg <= wb_dat_i[16:0];
                  word_reg  <= 8'h00;
                  if (wb_dat_i[amd_pkg::POS_CLASS_HI] | (wb_dat_i[amd_pkg::POS_SUBCLASS] & ~sup_1b))
                     bad_reg <= 1'b1;
                  else begin
                     bad_reg   <= 1'b0;
                     state_reg <= amd_pkg::AMD_ISSUE;
                  end
               end
            end
            amd_pkg::AMD_ISSUE: state_reg <= amd_pkg::AMD_WAIT;
            amd_pkg::AMD_WAIT:  state_reg <= amd_pkg::AMD_EXEC;
            amd_pkg::AMD_EXEC: begin
               if (last_word)
                  state_reg <= amd_pkg::AMD_IDLE;
               else begin
                  word_reg  <= word_reg + 8'h01;
                  state_reg <= amd_pkg::AMD_ISSUE;
               end
            end
            default: state_reg <= amd_pkg::AMD_IDLE;
         endcase
      end
   end

   // address generator and memory strobes
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         agen_adrs_o <= 8'h00;
         agen_load_o <= 1'b0;
         agen_step_o <= 1'b0;
         mem_rd_o    <= 1'b0;
         mem_wr_o    <= 1'b0;
         mem_wdata_o <= amd_pkg::RST_WORD;
         mem_be_o    <= 2'h0;
         pmem_rd_o   <= 1'b0;
         pmem_addr_o <= amd_pkg::RST_WORD;
      end else begin
         agen_load_o <= start_ok;
         if (start_ok)
            agen_adrs_o <= wb_dat_i[7:0];
         agen_step_o <= exec & ~last_word;
         mem_rd_o    <= (state_reg == amd_pkg::AMD_ISSUE) & ~is_store & ~is_table;
         pmem_rd_o   <= (state_reg == amd_pkg::AMD_ISSUE) & is_table;
         if ((state_reg == amd_pkg::AMD_ISSUE) & is_table)
            pmem_addr_o <= a_op;
         mem_wr_o    <= exec & wr_mem;
         if (exec & wr_mem) begin
            mem_wdata_o <= wdata;
            mem_be_o    <= be;
         end
      end
   end

   // accumulator file and pointers
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         for (int i = 0; i < 2*ACC_WORDS; i++)
            acc_file[i] <= amd_pkg::RST_WORD;
         for (int j = 0; j < 4; j++)
            ap_reg[j] <= amd_pkg::RST_PTR;
      end else begin
         // permanent pre-adjust, 1a only, never with string index
         if (start_ok & ~wb_dat_i[amd_pkg::POS_CLASS_HI] & ~wb_dat_i[amd_pkg::POS_SUBCLASS]
             & (wb_dat_i[amd_pkg::POS_ACCIDX_LO +: 2] != amd_pkg::IDX_STRING)) begin
            if (wb_dat_i[amd_pkg::POS_NEXTA_LO +: 2] == amd_pkg::NEXTA_INC)
               ap_reg[wb_dat_i[9:8]] <= ap_reg[wb_dat_i[9:8]] + 4'h1;
            else if (wb_dat_i[amd_pkg::POS_NEXTA_LO +: 2] == amd_pkg::NEXTA_DEC)
               ap_reg[wb_dat_i[9:8]] <= ap_reg[wb_dat_i[9:8]] - 4'h1;
         end
         if (exec & wr_acc)
            acc_file[tgt_addr] <= res;
      end
   end

   // status, multiplier and product-high registers
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         carry_reg     <= 1'b0;
         zero_reg      <= 1'b0;
         neg_reg       <= 1'b0;
         xzero_reg     <= 1'b0;
         xneg_reg      <= 1'b0;
         mr_signed_reg <= 1'b0;
         mr_reg        <= amd_pkg::RST_WORD;
         ph_reg        <= amd_pkg::RST_WORD;
      end else begin
         if (exec & upd_arith) begin
            carry_reg <= res_c;
            zero_reg  <= (res == 16'h0000) & (~chain | zero_reg);
            neg_reg   <= res[15];
         end
         if (exec & upd_xfer) begin
            xzero_reg <= wdata == 16'h0000;
            xneg_reg  <= wdata[15];
         end
         if (exec & ph_load)
            ph_reg <= prod[31:16];
         if (exec & mr_load) begin
            mr_reg        <= m_op;
            mr_signed_reg <= 1'b1;
         end else if (bus_wr & (wb_adr_i[4:0] == amd_pkg::ADDR_MULT)
                      & (state_reg == amd_pkg::AMD_IDLE)) begin
            if (wb_sel_i[0])
               mr_reg[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
               mr_reg[15:8] <= wb_dat_i[15:8];
            if (wb_sel_i[2])
               mr_signed_reg <= wb_dat_i[16];
         end
      end
   end

   // ****************************************************************
   // wishbone slave
   // ****************************************************************
   // single-wait answer, unmapped reads zero
   always_ff @(posedge clk_sys) begin
      if (srst) begin
         ack_reg    <= 1'b0;
         rdata_reg  <= 32'h00000000;
         strlen_reg <= amd_pkg::RST_STRLEN;
         accsel_reg <= 5'h00;
      end else begin
         ack_reg <= bus_req;
         if (bus_wr & wb_sel_i[0] & (state_reg == amd_pkg::AMD_IDLE)) begin
            if (wb_adr_i[4:0] == amd_pkg::ADDR_STRLEN)
               strlen_reg <= wb_dat_i[7:0];
            if (wb_adr_i[4:0] == amd_pkg::ADDR_ACCSEL)
               accsel_reg <= wb_dat_i[4:0];
         end
         if (bus_req) begin
            case (wb_adr_i[4:0])
               amd_pkg::ADDR_INSTR:    rdata_reg <= {15'h0000, instr_reg};
               amd_pkg::ADDR_STRLEN:   rdata_reg <= {24'h000000, strlen_reg};
               amd_pkg::ADDR_STATUS:   rdata_reg <= {24'h000000, bad_reg, mr_signed_reg, xneg_reg,
                                                     xzero_reg, neg_reg, zero_reg, carry_reg,
                                                     state_reg != amd_pkg::AMD_IDLE};
               amd_pkg::ADDR_MULT:     rdata_reg <= {15'h0000, mr_signed_reg, mr_reg};
               amd_pkg::ADDR_PRODHI:   rdata_reg <= {16'h0000, ph_reg};
               amd_pkg::ADDR_ACCSEL:   rdata_reg <= {27'h0000000, accsel_reg};
               amd_pkg::ADDR_ACCDATA:  rdata_reg <= {16'h0000, acc_file[accsel_reg]};
               amd_pkg::ADDR_POINTERS: rdata_reg <= {16'h0000, ap_reg[3], ap_reg[2],
                                                     ap_reg[1], ap_reg[0]};
               default:                rdata_reg <= 32'h00000000;
            endcase
         end
      end
   end

   assign wb_ack_o = ack_reg;
   assign wb_dat_o = rdata_reg;

   // ****************************************************************
   // checks
   // ****************************************************************
   adrs_forward_a: assert property (@(posedge clk_sys) disable iff (srst)
      mem_rd_o |-> agen_adrs_o == instr_reg[7:0])
      else $error("address field not forwarded");

   offset_target_a: assert property (@(posedge clk_sys) disable iff (srst)
      (exec & ~is_1a) |-> ~tgt_addr[4])
      else $error("second subclass hit offset bank");

   string_ptr_a: assert property (@(posedge clk_sys) disable iff (srst)
      (exec & is_1a & string_mode) |=> ap_reg[2'h3] == $past(ap_reg[2'h3], 2))
      else $error("string moved pointer");

   store_status_a: assert property (@(posedge clk_sys) disable iff (srst)
      (exec & is_store) |=> $stable(carry_reg) && $stable(zero_reg) && mem_wr_o)
      else $error("store touched arithmetic status");

   byte_zero_a: assert property (@(posedge clk_sys) disable iff (srst)
      (exec & ~is_1a & (op1b == amd_pkg::OP1B_BLOAD)) |-> wr_acc && res[15:8] == 8'h00)
      else $error("byte load upper not cleared");

   compare_keep_a: assert property (@(posedge clk_sys) disable iff (srst)
      (exec & ~is_1a & (op1b == amd_pkg::OP1B_CMP)) |-> ~wr_acc && ~wr_mem && upd_arith)
      else $error("compare wrote a result");

   prod_high_a: assert property (@(posedge clk_sys) disable iff (srst)
      (exec & ~is_1a & (op1b == amd_pkg::OP1B_MULT)) |=> ph_reg == $past(prod[31:16]))
      else $error("product high not latched");

   once_exec_a: assert property (@(posedge clk_sys) disable iff (srst)
      (exec & once_op) |=> state_reg == amd_pkg::AMD_IDLE ##1 ~agen_step_o)
      else $error("chained op repeated");

   reserved_quiet_a: assert property (@(posedge clk_sys) disable iff (srst)
      (exec & ~is_1a & (op1b == amd_pkg::OP1B_RSVD)) |-> ~wr_acc && ~wr_mem && ~upd_arith)
      else $error("reserved code had effect");

   bus_answer_a: assert property (@(posedge clk_sys) disable iff (srst)
      (wb_cyc_i & wb_stb_i & ~wb_ack_o) |=> wb_ack_o ##1 ~wb_ack_o)
      else $error("bus answer timing wrong");

endmodule

`default_nettype wire

// File: test/amd_decoder_test.sv
// self-checking bench for the memory/accumulator instruction decoder
// assumes the decoder answers every register access one cycle after the request
`timescale 1ns/1ps
`default_nettype none
module amd_decoder_test;
   logic clk_sys = 1'b0, srst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, lsb = 1'b0;
   logic [31:0] adr = 32'h0, dat = 32'h0, wb_dat_o, rs = 32'h4c758e27;
   logic [15:0] mem_rdata_i = 16'h0, pmem_rdata_i = 16'h0, mem_wdata_o, pmem_addr_o;
   logic [15:0] a, o, m, p;
   logic [31:0] prod;
   logic [63:0] rq[$], mq[$], e;
   logic [7:0] agen_adrs_o;
   logic [1:0] mem_be_o;
   logic wb_ack_o, agen_load_o, agen_step_o, mem_rd_o, mem_wr_o, pmem_rd_o;
   int failures = 0, tests_run = 0;
   int nld = 0, nst = 0, nrd = 0, npr = 0;
   logic cy;
   amd_decoder dut (.clk_sys(clk_sys), .srst(srst), .wb_adr_i(adr), .wb_dat_i(dat),
      .wb_sel_i(4'hf), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(wb_ack_o),
      .wb_dat_o(wb_dat_o), .agen_adrs_o(agen_adrs_o), .agen_load_o(agen_load_o),
      .agen_step_o(agen_step_o), .agen_addr_lsb_i(lsb), .mem_rd_o(mem_rd_o),
      .mem_rdata_i(mem_rdata_i), .mem_wr_o(mem_wr_o), .mem_wdata_o(mem_wdata_o),
      .mem_be_o(mem_be_o), .pmem_rd_o(pmem_rd_o), .pmem_addr_o(pmem_addr_o),
      .pmem_rdata_i(pmem_rdata_i));
   // ****************************************************************
   // clock, comparison and bus helpers
   // ****************************************************************
   always #25 clk_sys = ~clk_sys;
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] xs();
      rs = rs ^ (rs << 13);
      rs = rs ^ (rs >> 17);
      rs = rs ^ (rs << 5);
      return rs;
   endfunction
   // classic single cycle; a read notes its masked expectation first
   task automatic bus(input logic [4:0] ad, input logic w, input logic [31:0] d,
                      input logic [31:0] mk, input logic [31:0] ex);
      if (!w) rq.push_back({mk, ex});
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= {27'h0, ad}; dat <= d;
      do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic acc(input logic [4:0] i, input logic [15:0] ex);
      bus(amd_pkg::ADDR_ACCSEL, 1'b1, {27'h0, i}, 32'h0, 32'h0);
      bus(amd_pkg::ADDR_ACCDATA, 1'b0, 32'h0, 32'hffff, {16'h0, ex});
   endtask
   // issue an instruction, wait out 2+3*words cycles, count its strobes
   task automatic run(input logic [16:0] ins, input int words);
      int l0, s0, r0;
      l0 = nld;
      s0 = nst;
      r0 = nrd + npr;
      bus(amd_pkg::ADDR_INSTR, 1'b1, {15'h0, ins}, 32'h0, 32'h0);
      repeat (2 + 3 * words) @(posedge clk_sys);
      check(nld - l0, 1);
      check(nst - s0, words - 1);
      check(nrd + npr - r0, (ins[15:13] == 3'h3) ? 0 : words);
   endtask
   function automatic logic [16:0] i1a(logic [1:0] op, logic off, logic [1:0] nx, logic [1:0] ix);
      return {2'b00, op, off, nx, ix, 8'h5a};
   endfunction
   function automatic logic [16:0] i1b(logic [3:0] op, logic s);
      return {2'b01, op, s, 2'b00, 8'h3c};
   endfunction
   // ****************************************************************
   // monitor: compare each result with the oldest note
   // ****************************************************************
   always @(posedge clk_sys) begin
      nld += agen_load_o;
      nst += agen_step_o;
      nrd += mem_rd_o;
      npr += pmem_rd_o;
      if (wb_ack_o === 1'b1 && !we && rq.size() > 0) begin
         e = rq.pop_front();
         check(wb_dat_o & e[63:32], e[31:0]);
      end
      if (mem_wr_o === 1'b1 && mq.size() > 0) begin
         e = mq.pop_front();
         check({14'h0, mem_be_o, mem_wdata_o} & e[63:32], e[31:0]);
      end
   end
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      repeat (4000) @(posedge clk_sys);
      failures++;
      tally_and_finish();
   end
   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      repeat (3) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      bus(amd_pkg::ADDR_STATUS, 1'b0, 32'h0, 32'hff, 32'h0);
      m = xs(); mem_rdata_i <= m;
      run(i1a(amd_pkg::OP1A_LOAD, 1'b0, 2'b00, 2'b00), 1); a = m;
      acc(0, a);
      check({24'h0, agen_adrs_o}, 32'h5a);
      m = xs(); mem_rdata_i <= m; o = a + m;
      run(i1a(amd_pkg::OP1A_ADD, 1'b1, 2'b00, 2'b00), 1);
      acc(16, o);
      acc(0, a);
      m = xs(); mem_rdata_i <= m; a = a - m;
      run(i1a(amd_pkg::OP1A_SUB, 1'b0, 2'b00, 2'b00), 1);
      acc(0, a);
      bus(amd_pkg::ADDR_STATUS, 1'b0, 32'h0, 32'hc, {28'h0, a[15], a == 16'h0, 2'b0});
      for (int k = 0; k < 3; k++) begin
         m = xs(); mem_rdata_i <= m;
         run(i1b(k[3:0], 1'b0), 1);
         a = (k == 0) ? (a | m) : (k == 1) ? (a & m) : (a ^ m);
         acc(0, a);
      end
      mem_rdata_i <= a;
      run(i1b(amd_pkg::OP1B_CMP, 1'b0), 1);
      acc(0, a);
      bus(amd_pkg::ADDR_STATUS, 1'b0, 32'h0, 32'h4, 32'h4);
      m = xs(); mem_rdata_i <= m; lsb <= 1'b1; a = {8'h0, m[15:8]};
      run(i1b(amd_pkg::OP1B_BLOAD, 1'b0), 1);
      acc(0, a);
      mq.push_back({32'h3ff00, 14'h0, 2'b10, a[7:0], 8'h0});
      run(i1b(amd_pkg::OP1B_BSTOR, 1'b0), 1);
      mq.push_back({32'h3ffff, 14'h0, 2'b11, o});
      run(i1a(amd_pkg::OP1A_STORE, 1'b1, 2'b00, 2'b00), 1);
      p = xs(); pmem_rdata_i <= p;
      mq.push_back({32'h3ffff, 14'h0, 2'b11, p});
      run(i1b(amd_pkg::OP1B_TABLE, 1'b0), 1);
      check({16'h0, pmem_addr_o}, {16'h0, a});
      bus(amd_pkg::ADDR_STATUS, 1'b0, 32'h0, 32'h30, {26'h0, p[15], p == 16'h0, 4'h0});
      bus(amd_pkg::ADDR_MULT, 1'b1, 32'h8001, 32'h0, 32'h0);
      mem_rdata_i <= 16'h1234; prod = 32'h8001 * 32'h1234; a = prod[15:0];
      run(i1b(amd_pkg::OP1B_MULT, 1'b0), 1);
      acc(0, a);
      bus(amd_pkg::ADDR_PRODHI, 1'b0, 32'h0, 32'hffff, {16'h0, prod[31:16]});
      cy = a >= prod[31:16]; // carry means no borrow
      mem_rdata_i <= 16'h0777; a = a - prod[31:16];
      run(i1b(amd_pkg::OP1B_SUBPH, 1'b0), 1);
      acc(0, a);
      bus(amd_pkg::ADDR_MULT, 1'b0, 32'h0, 32'h1ffff, 32'h10777);
      bus(amd_pkg::ADDR_STRLEN, 1'b1, 32'h3, 32'h0, 32'h0);
      a = a + prod[31:16] + {15'h0, cy};
      run(i1b(amd_pkg::OP1B_ADDPH, 1'b1), 1);
      acc(0, a);
      run(i1b(amd_pkg::OP1B_RSVD, 1'b0), 1);
      acc(0, a);
      acc(16, o);
      bus(amd_pkg::ADDR_STRLEN, 1'b1, 32'h1, 32'h0, 32'h0);
      m = xs(); mem_rdata_i <= m;
      run(i1a(amd_pkg::OP1A_LOAD, 1'b0, amd_pkg::NEXTA_INC, amd_pkg::IDX_STRING), 2);
      acc(1, m);
      bus(amd_pkg::ADDR_POINTERS, 1'b0, 32'h0, 32'hf000, 32'h0);
      p = xs(); mem_rdata_i <= p;
      run(i1b(amd_pkg::OP1B_OR, 1'b1), 2);
      acc(0, m | p);
      acc(1, m | p);
      run(i1a(amd_pkg::OP1A_LOAD, 1'b0, amd_pkg::NEXTA_INC, 2'b00), 1);
      bus(amd_pkg::ADDR_POINTERS, 1'b0, 32'h0, 32'hf, 32'h1);
      acc(1, p);
      run(i1a(amd_pkg::OP1A_ADD, 1'b0, amd_pkg::NEXTA_DEC, 2'b00), 1);
      bus(amd_pkg::ADDR_POINTERS, 1'b0, 32'h0, 32'hf, 32'h0);
      bus(amd_pkg::ADDR_INSTR, 1'b1, 32'h1ffff, 32'h0, 32'h0);
      bus(amd_pkg::ADDR_STATUS, 1'b0, 32'h0, 32'h81, 32'h80);
      tally_and_finish();
   end
endmodule
`default_nettype wire
